// ---- rtl/seq_ctl_defs.svh ----
`ifndef SEQ_CTL_DEFS_SVH
`define SEQ_CTL_DEFS_SVH

// Register byte addresses on the APB.
`define BUS_CONTROL_OFS 12'h000
`define BUS_STATUS_OFS 12'h004
`define RX_DATA_OFS 12'h008

// Reset values.
`define BUS_CONTROL_RST 16'h0000
`define RX_DATA_RST 8'h00

// Field positions in bus_control.
`define CTL_ENABLE 15
`define CTL_ACK_VALUE 5
`define CTL_ACK_GO 4
`define CTL_RECV_GO 3
`define CTL_STOP_GO 2
`define CTL_RESTART_GO 1
`define CTL_START_GO 0

// Field positions in bus_status.
`define STAT_BUSY 14
`define STAT_STOP_SEEN 4
`define STAT_START_SEEN 3
`define STAT_DIRECTION 2
`define STAT_RX_FULL 1

// Timing: one quarter of a bus bit period.
`define MCLK_NS 25
`define QUARTER_NS 2500
`define QUARTER_CYC ((`QUARTER_NS + `MCLK_NS - 1) / `MCLK_NS)

`endif

// ---- rtl/seq_ctl_pkg.sv ----
package seq_ctl_pkg;

    typedef enum logic [2:0] {
        st_idle,
        st_start,
        st_restart,
        st_stop,
        st_recv,
        st_ack
    } seq_state_t;

    typedef struct packed {
        logic scl;
        logic sda;
    } line_pair_t;

    typedef struct packed {
        logic start_seen;
        logic stop_seen;
        logic addr_done;
        logic direction;
    } bus_event_t;

endpackage

// ---- rtl/quarter_timer.sv ----
`timescale 1ns/1ps
`include "seq_ctl_defs.svh"

module quarter_timer
(
    // Clock and reset.
    input wire logic mclk,
    input wire logic rst_b,
    // Control.
    input wire logic run,
    input wire logic hold,
    // Quarter period pulse.
    output logic tick
);

    localparam logic [11:0] LAST = 12'(`QUARTER_CYC - 1);

    logic [11:0] count_reg;

    // Counts quarter periods while running; a stretched clock pauses it.
    always_ff @(posedge mclk)
    begin
        if (!rst_b || !run)
        begin
            count_reg <= 12'h000;
            tick <= 1'b0;
        end
        else if (hold)
        begin
            tick <= 1'b0;
        end
        else if (count_reg == LAST)
        begin
            count_reg <= 12'h000;
            tick <= 1'b1;
        end
        else
        begin
            count_reg <= count_reg + 12'h001;
            tick <= 1'b0;
        end
    end

endmodule

// ---- rtl/line_monitor.sv ----
`timescale 1ns/1ps

module line_monitor
(
    // Clock and reset.
    input wire logic mclk,
    input wire logic rst_b,
    // Raw bus lines.
    input seq_ctl_pkg::line_pair_t line_in,
    // Synchronised lines and detected events.
    output seq_ctl_pkg::line_pair_t line_sync,
    output seq_ctl_pkg::bus_event_t bus_event
);

    seq_ctl_pkg::line_pair_t meta_reg;
    seq_ctl_pkg::line_pair_t last_reg;
    logic [3:0] edge_cnt_reg;
    logic armed_reg;
    logic scl_rise;

    // Two flip-flops before any logic sees the lines.
    always_ff @(posedge mclk)
    begin
        if (!rst_b)
        begin
            meta_reg <= 2'h3;
            line_sync <= 2'h3;
            last_reg <= 2'h3;
        end
        else
        begin
            meta_reg <= line_in;
            line_sync <= meta_reg;
            last_reg <= line_sync;
        end
    end

    assign scl_rise = line_sync.scl && !last_reg.scl;

    // Start and stop are data edges while the clock line is high.
    always_comb
    begin
        bus_event.start_seen = line_sync.scl && last_reg.scl &&
            last_reg.sda && !line_sync.sda;
        bus_event.stop_seen = line_sync.scl && last_reg.scl &&
            !last_reg.sda && line_sync.sda;
        bus_event.addr_done = armed_reg && scl_rise &&
            (edge_cnt_reg == 4'h7);
        bus_event.direction = line_sync.sda;
    end

    // The eighth clock after a start carries the direction bit.
    always_ff @(posedge mclk)
    begin
        if (!rst_b || bus_event.stop_seen)
        begin
            armed_reg <= 1'b0;
            edge_cnt_reg <= 4'h0;
        end
        else if (bus_event.start_seen)
        begin
            armed_reg <= 1'b1;
            edge_cnt_reg <= 4'h0;
        end
        else if (armed_reg && scl_rise)
        begin
            edge_cnt_reg <= edge_cnt_reg + 4'h1;
            if (edge_cnt_reg == 4'h7)
            begin
                armed_reg <= 1'b0;
            end
        end
    end

endmodule

// ---- rtl/i2c_master_sequence_control.sv ----
`timescale 1ns/1ps
`include "seq_ctl_defs.svh"

module i2c_master_sequence_control
(
    // Clock and reset.
    input wire logic mclk,
    input wire logic rst_b,
    // APB slave.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Serial clock line, open drain.
    input wire logic serial_clock_line_in,
    output logic serial_clock_line_out,
    output logic serial_clock_line_oe_b,
    // Serial data line, open drain.
    input wire logic serial_data_line_in,
    output logic serial_data_line_out,
    output logic serial_data_line_oe_b
);

    seq_ctl_pkg::seq_state_t state_reg;
    seq_ctl_pkg::line_pair_t line_in;
    seq_ctl_pkg::line_pair_t line_sync;
    seq_ctl_pkg::bus_event_t bus_event;

    logic enable_reg;
    logic ack_value_select_reg;
    logic [4:0] go_reg;
    logic [4:0] go_next;
    logic [4:0] done_mask;
    logic [1:0] step_reg;
    logic [2:0] bit_reg;
    logic [7:0] shift_reg;
    logic [7:0] rx_reg;
    logic rx_full_reg;
    logic stop_seen_reg;
    logic start_seen_reg;
    logic direction_reg;
    logic tick;
    logic hold;
    logic last_step;
    logic setup;
    logic access;
    logic wr_ctrl;
    logic rd_rx;
    logic [15:0] status;
    logic [15:0] control;

    assign line_in.scl = serial_clock_line_in;
    assign line_in.sda = serial_data_line_in;

    line_monitor u_line_monitor
    (
        .mclk(mclk),
        .rst_b(rst_b),
        .line_in(line_in),
        .line_sync(line_sync),
        .bus_event(bus_event)
    );

    // A released clock held low by a target stalls the quarter timer.
    assign hold = serial_clock_line_oe_b && !line_sync.scl;

    quarter_timer u_quarter_timer
    (
        .mclk(mclk),
        .rst_b(rst_b),
        .run(state_reg != seq_ctl_pkg::st_idle),
        .hold(hold),
        .tick(tick)
    );

    // APB decode: no wait state, the answer comes with pready.
    assign setup = psel && !penable;
    assign access = psel && penable && pready;
    assign wr_ctrl = access && pwrite && (paddr == `BUS_CONTROL_OFS);
    assign rd_rx = access && !pwrite && (paddr == `RX_DATA_OFS);

    always_comb
    begin
        control = `BUS_CONTROL_RST;
        control[`CTL_ENABLE] = enable_reg;
        control[`CTL_ACK_VALUE] = ack_value_select_reg;
        control[`CTL_ACK_GO:`CTL_START_GO] = go_reg;
        status = 16'h0000;
        status[`STAT_BUSY] = state_reg != seq_ctl_pkg::st_idle;
        status[`STAT_STOP_SEEN] = stop_seen_reg;
        status[`STAT_START_SEEN] = start_seen_reg;
        status[`STAT_DIRECTION] = direction_reg;
        status[`STAT_RX_FULL] = rx_full_reg;
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_b)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end
        else if (setup)
        begin
            pready <= 1'b1;
            pslverr <= !((paddr == `BUS_CONTROL_OFS) ||
                (paddr == `BUS_STATUS_OFS) || (paddr == `RX_DATA_OFS));
            if (paddr == `BUS_CONTROL_OFS)
            begin
                prdata <= {16'h0000, control};
            end
            else if (paddr == `BUS_STATUS_OFS)
            begin
                prdata <= {16'h0000, status};
            end
            else if (paddr == `RX_DATA_OFS)
            begin
                prdata <= {24'h000000, rx_reg};
            end
            else
            begin
                prdata <= 32'h00000000;
            end
        end
        else
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    // Plain control fields written by software.
    always_ff @(posedge mclk)
    begin
        if (!rst_b)
        begin
            enable_reg <= 1'b0;
            ack_value_select_reg <= 1'b0;
        end
        else if (wr_ctrl)
        begin
            enable_reg <= pwdata[`CTL_ENABLE];
            ack_value_select_reg <= pwdata[`CTL_ACK_VALUE];
        end
    end

    // The last quarter of a sequence ends it.
    assign last_step = tick && (step_reg == 2'h3) &&
        ((state_reg != seq_ctl_pkg::st_recv) || (bit_reg == 3'h7));

    always_comb
    begin
        done_mask = 5'h00;
        if (last_step)
        begin
            unique case (state_reg)
                seq_ctl_pkg::st_start: done_mask[`CTL_START_GO] = 1'b1;
                seq_ctl_pkg::st_restart:
                    done_mask[`CTL_RESTART_GO] = 1'b1;
                seq_ctl_pkg::st_stop: done_mask[`CTL_STOP_GO] = 1'b1;
                seq_ctl_pkg::st_recv: done_mask[`CTL_RECV_GO] = 1'b1;
                seq_ctl_pkg::st_ack: done_mask[`CTL_ACK_GO] = 1'b1;
                seq_ctl_pkg::st_idle: done_mask = 5'h00;
            endcase
        end
    end

    // Go bits set by software writing ones with the enable bit in the same write, cleared by hardware at the end;
    // a set in the same cycle as the clear wins.
    always_comb
    begin
        go_next = go_reg & ~done_mask;
        if (wr_ctrl && pwdata[`CTL_ENABLE])
        begin
            go_next = go_next | pwdata[`CTL_ACK_GO:`CTL_START_GO];
        end
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_b)
        begin
            go_reg <= 5'h00;
        end
        else
        begin
            go_reg <= go_next;
        end
    end

    // Sequencer: each step is one quarter bit period.
    always_ff @(posedge mclk)
    begin
        if (!rst_b)
        begin
            state_reg <= seq_ctl_pkg::st_idle;
            step_reg <= 2'h0;
            bit_reg <= 3'h0;
            shift_reg <= 8'h00;
            serial_clock_line_oe_b <= 1'b1;
            serial_data_line_oe_b <= 1'b1;
        end
        else if (state_reg == seq_ctl_pkg::st_idle)
        begin
            step_reg <= 2'h0;
            bit_reg <= 3'h0;
            // One request at a time; the lowest set bit is served.
            if (go_reg[`CTL_START_GO])
                state_reg <= seq_ctl_pkg::st_start;
            else if (go_reg[`CTL_RESTART_GO])
                state_reg <= seq_ctl_pkg::st_restart;
            else if (go_reg[`CTL_STOP_GO])
                state_reg <= seq_ctl_pkg::st_stop;
            else if (go_reg[`CTL_RECV_GO])
                state_reg <= seq_ctl_pkg::st_recv;
            else if (go_reg[`CTL_ACK_GO])
                state_reg <= seq_ctl_pkg::st_ack;
        end
        else if (tick)
        begin
            step_reg <= step_reg + 2'h1;
            unique case (state_reg)
                seq_ctl_pkg::st_start:
                begin
                    if (step_reg == 2'h0)
                        serial_data_line_oe_b <= 1'b0;
                    if (step_reg == 2'h2)
                        serial_clock_line_oe_b <= 1'b0;
                end
                seq_ctl_pkg::st_restart:
                begin
                    if (step_reg == 2'h0)
                        serial_data_line_oe_b <= 1'b1;
                    if (step_reg == 2'h1)
                        serial_clock_line_oe_b <= 1'b1;
                    if (step_reg == 2'h2)
                        serial_data_line_oe_b <= 1'b0;
                    if (step_reg == 2'h3)
                        serial_clock_line_oe_b <= 1'b0;
                end
                seq_ctl_pkg::st_stop:
                begin
                    if (step_reg == 2'h0)
                        serial_data_line_oe_b <= 1'b0;
                    if (step_reg == 2'h1)
                        serial_clock_line_oe_b <= 1'b1;
                    if (step_reg == 2'h2)
                        serial_data_line_oe_b <= 1'b1;
                end
                seq_ctl_pkg::st_recv:
                begin
                    if (step_reg == 2'h0)
                        serial_data_line_oe_b <= 1'b1;
                    if (step_reg == 2'h1)
                        serial_clock_line_oe_b <= 1'b1;
                    if (step_reg == 2'h2)
                        shift_reg <= {shift_reg[6:0], line_sync.sda};
                    if (step_reg == 2'h3)
                    begin
                        serial_clock_line_oe_b <= 1'b0;
                        bit_reg <= bit_reg + 3'h1;
                    end
                end
                seq_ctl_pkg::st_ack:
                begin
                    if (step_reg == 2'h0)
                        serial_data_line_oe_b <= ack_value_select_reg;
                    if (step_reg == 2'h1)
                        serial_clock_line_oe_b <= 1'b1;
                    if (step_reg == 2'h3)
                        serial_clock_line_oe_b <= 1'b0;
                end
                seq_ctl_pkg::st_idle:
                begin
                    step_reg <= 2'h0;
                end
            endcase
            if (last_step)
                state_reg <= seq_ctl_pkg::st_idle;
        end
    end

    // Received byte and its full flag; a new byte wins over a read.
    always_ff @(posedge mclk)
    begin
        if (!rst_b)
        begin
            rx_reg <= `RX_DATA_RST;
            rx_full_reg <= 1'b0;
        end
        else if (last_step && (state_reg == seq_ctl_pkg::st_recv))
        begin
            rx_reg <= shift_reg;
            rx_full_reg <= 1'b1;
        end
        else if (rd_rx)
        begin
            rx_full_reg <= 1'b0;
        end
    end

    // Bus condition and direction flags.
    always_ff @(posedge mclk)
    begin
        if (!rst_b)
        begin
            stop_seen_reg <= 1'b0;
            start_seen_reg <= 1'b0;
            direction_reg <= 1'b0;
        end
        else
        begin
            if (bus_event.start_seen)
            begin
                start_seen_reg <= 1'b1;
                stop_seen_reg <= 1'b0;
            end
            else if (bus_event.stop_seen)
            begin
                start_seen_reg <= 1'b0;
                stop_seen_reg <= 1'b1;
            end
            if (bus_event.addr_done)
                direction_reg <= bus_event.direction;
        end
    end

    // Open-drain data outputs are held low; only the enables move.
    always_ff @(posedge mclk)
    begin
        serial_clock_line_out <= 1'b0;
        serial_data_line_out <= 1'b0;
    end

endmodule

// ---- sim/i2c_seq_properties.sv ----
`timescale 1ns/1ps
`include "seq_ctl_defs.svh"

module i2c_seq_properties
(
    // Clock and reset.
    input wire logic mclk,
    input wire logic rst_b,
    // APB.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Bus lines.
    input wire logic serial_clock_line_in,
    input wire logic serial_clock_line_out,
    input wire logic serial_clock_line_oe_b,
    input wire logic serial_data_line_in,
    input wire logic serial_data_line_out,
    input wire logic serial_data_line_oe_b
);
    logic wr_ctl;
    logic ack_val_reg;

    default clocking @(posedge mclk);
    endclocking
    default disable iff (!rst_b);

    assign wr_ctl = psel & penable & pready & pwrite
        & (paddr == `BUS_CONTROL_OFS) & pwdata[`CTL_ENABLE];

    always_ff @(posedge mclk)
    begin
        if (!rst_b)
            ack_val_reg <= 1'h0;
        else if (wr_ctl)
            ack_val_reg <= pwdata[`CTL_ACK_VALUE];
    end

    AST_PREADY_SETUP: assert property (psel && !penable |=> pready)
        else $error("no answer after setup");
    AST_PREADY_PULSE: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    AST_UNMAPPED: assert property (psel && penable && pready
        && paddr > `RX_DATA_OFS |-> pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");
    AST_OPEN_DRAIN: assert property
        (serial_clock_line_out == 1'h0 && serial_data_line_out == 1'h0)
        else $error("line driven high");
    AST_RESET_IDLE: assert property (disable iff (1'h0) !rst_b |=>
        serial_clock_line_oe_b && serial_data_line_oe_b && !pready)
        else $error("lines not released in reset");
    AST_START: assert property (
        wr_ctl && pwdata[1:0] == 2'h1 |-> ##[100:110]
        (!serial_data_line_oe_b && serial_clock_line_oe_b))
        else $error("start condition missing");
    AST_RESTART: assert property (
        wr_ctl && pwdata[1:0] == 2'h2 |-> ##[300:320]
        ($fell(serial_data_line_oe_b) && serial_clock_line_oe_b))
        else $error("repeated start missing");
    AST_STOP: assert property (
        wr_ctl && pwdata[2:0] == 3'h4 |-> ##[300:320]
        ($rose(serial_data_line_oe_b) && serial_clock_line_oe_b))
        else $error("stop condition missing");
    AST_RECEIVE: assert property (
        wr_ctl && pwdata[3:0] == 4'h8 |-> ##[200:210]
        ($rose(serial_clock_line_oe_b) && serial_data_line_oe_b))
        else $error("receive bit clock missing");
    AST_ACK_SLOT: assert property (
        wr_ctl && pwdata[4:0] == 5'h10 |-> ##[90:400]
        ($rose(serial_clock_line_in)
        && serial_data_line_oe_b == ack_val_reg))
        else $error("acknowledge slot wrong");

    cover property (wr_ctl && pwdata[`CTL_START_GO]);
    cover property (wr_ctl && pwdata[`CTL_ACK_GO] && pwdata[5]);
    cover property (pready && pslverr);
endmodule

bind i2c_master_sequence_control i2c_seq_properties i2c_seq_properties_i
(
    .mclk(mclk), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr),
    .serial_clock_line_in(serial_clock_line_in),
    .serial_clock_line_out(serial_clock_line_out),
    .serial_clock_line_oe_b(serial_clock_line_oe_b),
    .serial_data_line_in(serial_data_line_in),
    .serial_data_line_out(serial_data_line_out),
    .serial_data_line_oe_b(serial_data_line_oe_b)
);

// ---- sim/i2c_target_model.sv ----
`timescale 1ns/1ps

module i2c_target_model
(
    // Wired bus levels.
    input wire logic scl,
    input wire logic sda,
    // Behaviour.
    input wire logic [7:0] tx_byte,
    input wire logic [15:0] stretch_ns,
    // Open-drain drives and seen acknowledge.
    output logic scl_oe_b,
    output logic sda_oe_b,
    output logic ack_seen
);
    int cnt = 0;

    initial scl_oe_b = 1'h1;
    initial ack_seen = 1'h0;

    // Start, repeated start and stop all restart the bit count.
    always @(sda)
    begin
        if (scl === 1'h1)
            cnt = 0;
    end

    always @(negedge scl)
    begin
        cnt = (cnt == 9) ? 1 : cnt + 1;
        if (stretch_ns != 16'h0)
        begin
            scl_oe_b = 1'h0;
            #(stretch_ns);
            scl_oe_b = 1'h1;
        end
    end

    always @(posedge scl)
    begin
        if (cnt == 9)
            ack_seen = sda;
    end

    // Bits go out MSB first; the ninth slot is left free.
    assign sda_oe_b = (cnt >= 1 && cnt <= 8) ? tx_byte[3'(8 - cnt)] : 1'h1;
endmodule

// ---- sim/test_i2c_master_sequence_control.sv ----
`timescale 1ns/1ps
`include "seq_ctl_defs.svh"

module test_i2c_master_sequence_control;
    logic mclk, rst_b, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic scl_out, scl_oe_b, sda_out, sda_oe_b, e, a, ack_seen;
    logic tgt_scl_oe_b, tgt_sda_oe_b;
    logic [7:0] tx_byte, b;
    logic [15:0] stretch_ns;
    int mismatches, checked;
    wire scl = (scl_oe_b | scl_out) & tgt_scl_oe_b;
    wire sda = (sda_oe_b | sda_out) & tgt_sda_oe_b;

    i2c_master_sequence_control i2c_master_sequence_control_i
    (
        .mclk(mclk), .rst_b(rst_b), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr),
        .serial_clock_line_in(scl), .serial_clock_line_out(scl_out),
        .serial_clock_line_oe_b(scl_oe_b),
        .serial_data_line_in(sda), .serial_data_line_out(sda_out),
        .serial_data_line_oe_b(sda_oe_b)
    );

    i2c_target_model i2c_target_model_i
    (
        .scl(scl), .sda(sda), .tx_byte(tx_byte), .stretch_ns(stretch_ns),
        .scl_oe_b(tgt_scl_oe_b), .sda_oe_b(tgt_sda_oe_b),
        .ack_seen(ack_seen)
    );

    task automatic print_verdict();
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp,
        input logic [31:0] got);
        checked++;
        if (got !== exp)
        begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic apb(input logic wr, input logic [11:0] adr,
        input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'h1;
        pwrite <= wr;
        paddr <= adr;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'h1;
        do
        begin
            @(posedge mclk);
            n++;
        end
        while (pready !== 1'h1);
        q = prdata;
        e = pslverr;
        chk("access cycles", 32'h1, 32'(n));
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge mclk);
    endtask

    task automatic poll(input int pos);
        int n;
        n = 0;
        do
        begin
            apb(1'h0, `BUS_CONTROL_OFS, 32'h0);
            n++;
        end
        while (q[pos] !== 1'h0 && n < 4000);
        chk("go bit", 32'h0, {31'h0, q[pos]});
    endtask

    function automatic logic [31:0] go_word(input int pos, input logic k);
        return (32'h1 << `CTL_ENABLE) | (32'h1 << pos) | {26'h0, k, 5'h0};
    endfunction

    function automatic logic [31:0] flags_exp(input logic stop_last);
        return {27'h0, stop_last, ~stop_last, 3'h0};
    endfunction

    task automatic flags(input logic stop_last);
        apb(1'h0, `BUS_STATUS_OFS, 32'h0);
        chk("start stop flags", flags_exp(stop_last), q & 32'h4018);
    endtask

    initial
    begin
        mclk = 1'h0;
        forever #12.5 mclk = ~mclk;
    end

    initial
    begin
        #2000000;
        mismatches++;
        print_verdict();
    end

    initial
    begin
        rst_b = 1'h0;
        psel = 1'h0;
        penable = 1'h0;
        pwrite = 1'h0;
        paddr = 12'h0;
        pwdata = 32'h0;
        tx_byte = 8'hFF;
        stretch_ns = 16'h0;
        mismatches = 0;
        checked = 0;
        void'($urandom(3));
        repeat (2) @(posedge mclk);
        rst_b <= 1'h1;
        @(posedge mclk);
        apb(1'h0, `BUS_CONTROL_OFS, 32'h0);
        chk("control reset", 32'h0, q);
        apb(1'h0, `RX_DATA_OFS, 32'h0);
        chk("rx reset", 32'h0, q);
        apb(1'h0, 12'h00C, 32'h0);
        chk("unmapped error", 32'h1, {31'h0, e});
        chk("unmapped data", 32'h0, q);
        apb(1'h1, `BUS_CONTROL_OFS, 32'h1);
        apb(1'h0, `BUS_CONTROL_OFS, 32'h0);
        chk("go while disabled", 32'h0, q);
        apb(1'h1, `BUS_CONTROL_OFS, go_word(0, 1'h0));
        poll(0);
        flags(1'h0);
        for (int i = 0; i < 4; i++)
        begin
            b = (i == 1) ? 8'h00 : (i == 3) ? 8'hFF : 8'($urandom);
            a = (i < 2) ? i[0] : 1'($urandom);
            tx_byte <= b;
            stretch_ns <= (i == 2) ? 16'h1770 : 16'h0;
            apb(1'h1, `BUS_CONTROL_OFS, go_word(3, 1'h0));
            poll(3);
            apb(1'h0, `BUS_STATUS_OFS, 32'h0);
            chk("rx full", 32'h1, {31'h0, q[`STAT_RX_FULL]});
            apb(1'h0, `RX_DATA_OFS, 32'h0);
            chk("rx byte", {24'h0, b}, q);
            if (i == 0)
            begin
                apb(1'h0, `BUS_STATUS_OFS, 32'h0);
                chk("direction", {31'h0, b[0]}, {31'h0, q[2]});
                chk("rx full", 32'h0, {31'h0, q[`STAT_RX_FULL]});
            end
            stretch_ns <= 16'h0;
            apb(1'h1, `BUS_CONTROL_OFS, go_word(4, a));
            poll(4);
            chk("ack slot", {31'h0, a}, {31'h0, ack_seen});
        end
        tx_byte <= 8'hFF;
        apb(1'h1, `BUS_CONTROL_OFS, go_word(1, 1'h0));
        poll(1);
        flags(1'h0);
        apb(1'h1, `BUS_CONTROL_OFS, go_word(2, 1'h0));
        poll(2);
        flags(1'h1);
        apb(1'h1, `BUS_CONTROL_OFS, go_word(0, 1'h0));
        poll(0);
        flags(1'h0);
        print_verdict();
    end
endmodule
